// >>> hw/swd_map.svh
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH

// Core clock rate and period
`define SWD_CLK_KHZ 125000
`define SWD_CLK_PERIOD_NS 8

// Watchdog timeout in milliseconds
`define SWD_WDT_TIMEOUT_MS 2400

// Supervisor reset hold after supply recovery, milliseconds
`define SWD_RST_HOLD_MS 300

// Shortest activity level the processor holds, nanoseconds
`define SWD_MIN_LEVEL_NS 50

// Counter widths
`define SWD_WDT_CNT_W 29
`define SWD_RST_CNT_W 26

// Synchroniser depth for pin inputs
`define SWD_SYNC_STAGES 3

// Synchroniser word: bit positions and idle levels
`define SWD_PIN_COUNT 3
`define SWD_PIN_ACT 0
`define SWD_PIN_FLOAT 1
`define SWD_PIN_MR 2
`define SWD_PIN_IDLE 3'h4

// Derived cycle counts
`define SWD_WDT_CYCLES (`SWD_WDT_TIMEOUT_MS * `SWD_CLK_KHZ)
`define SWD_RST_CYCLES (`SWD_RST_HOLD_MS * `SWD_CLK_KHZ)
`define SWD_MIN_LEVEL_CYCLES ((`SWD_MIN_LEVEL_NS + `SWD_CLK_PERIOD_NS - 1) / `SWD_CLK_PERIOD_NS)

`endif

// >>> hw/swd_pkg.sv
package swd_pkg;

  // Watchdog states, Gray coded along idle, armed, counting, expired
  typedef enum logic [1:0] {
    SWD_IDLE    = 2'h0,
    SWD_ARMED   = 2'h1,
    SWD_COUNT   = 2'h3,
    SWD_EXPIRED = 2'h2
  } swd_state_t;

endpackage

// >>> hw/swd_pin_sync.sv
`timescale 1ns/1ps
`include "swd_map.svh"

module swd_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] edge_out
);
  import swd_pkg::*;

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;
  logic [WIDTH-1:0] edge_reg;
  logic [WIDTH-1:0] edge_next;
  logic [2:0] fill_cnt_reg;
  logic [2:0] fill_cnt_next;

  localparam logic [2:0] FILL_DONE = 3'(`SWD_SYNC_STAGES);

  // Idle level while the chain fills, then its output loaded with no edge
  always_comb begin
    level_next = level_reg;
    edge_next = '0;
    fill_cnt_next = fill_cnt_reg;
    if (fill_cnt_reg <= FILL_DONE) begin
      fill_cnt_next = fill_cnt_reg + 3'h1;
    end
    for (int i = 0; i < WIDTH; i++) begin
      if (fill_cnt_reg < FILL_DONE) begin
        level_next[i] = reset_level[i];
      end else if (fill_cnt_reg == FILL_DONE) begin
        level_next[i] = stage3_reg[i];
      end else if ((stage2_reg[i] == stage3_reg[i]) && (stage3_reg[i] != level_reg[i])) begin
        level_next[i] = stage3_reg[i];
        edge_next[i] = 1'b1;
      end
    end
  end

  // Three-stage chain and filtered level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
      edge_reg <= '0;
      fill_cnt_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
      edge_reg <= edge_next;
      fill_cnt_reg <= fill_cnt_next;
    end
  end

  assign level_out = level_reg;
  assign edge_out = edge_reg;
endmodule

// >>> hw/swd_watchdog.sv
`timescale 1ns/1ps
`include "swd_map.svh"

// Notes on behaviour
// - With no activity edge for the full 2.4 s timeout the fault output goes low.
// - After a timeout the fault output stays low until a new activity edge is seen, the activity pin floats or the supervisor reset is asserted.
// - While the activity pin floats the watchdog counter is held cleared and idle.
// - While the supervisor reset is asserted the watchdog is disabled and cleared.
// - After reset releases, the first activity edge of either sense starts a 2.4 s count.
// - Every later activity edge clears the counter and restarts a full count.
// - While the supply is below threshold the fault output is driven low.
// - When the supply recovers the fault output rises at once, with no reset delay.
// - The fault output has no minimum low time and follows its causes directly.
// - The supervisor reset stays asserted while the supply is low and releases 300 ms later.
module swd_watchdog #(
  parameter int unsigned TIMEOUT_CYCLES = `SWD_WDT_CYCLES,
  parameter int unsigned RST_HOLD_CYCLES = `SWD_RST_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic activity_input,
  input wire logic activity_float,
  input wire logic manual_reset_in_n,
  input wire logic supply_ok,
  output logic watchdog_fault_n,
  output logic supervisor_reset_n,
  output logic watchdog_running,
  output swd_pkg::swd_state_t watchdog_state
);
  import swd_pkg::*;

  localparam int WDT_W = `SWD_WDT_CNT_W;
  localparam int RST_W = `SWD_RST_CNT_W;

  // Pin positions and idle levels in the synchroniser word
  localparam int PIN_N = `SWD_PIN_COUNT;
  localparam int PIN_ACT = `SWD_PIN_ACT;
  localparam int PIN_FLOAT = `SWD_PIN_FLOAT;
  localparam int PIN_MR = `SWD_PIN_MR;
  localparam logic [PIN_N-1:0] PIN_IDLE = `SWD_PIN_IDLE;

  // Synchronised pin levels and edge pulses
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_level;
  logic [PIN_N-1:0] pin_edge;
  logic act_edge;
  logic act_floating;
  logic manual_low;

  // Supervisor reset generator state
  logic [RST_W-1:0] rst_cnt_reg;
  logic [RST_W-1:0] rst_cnt_next;
  logic sup_rst_n_reg;
  logic sup_rst_n_next;
  logic rst_cause;

  // Watchdog state
  swd_state_t state_reg;
  swd_state_t state_next;
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic [WDT_W-1:0] wdt_cnt_next;
  logic fault_n_reg;
  logic fault_n_next;
  logic running_reg;
  logic running_next;
  logic hold_rst;
  logic hold_float;
  logic fault_supply;
  logic fault_expiry;

  // Last-cycle decode, shared by the reset and watchdog counters
  function automatic logic count_done(input logic [31:0] cnt, input logic [31:0] last);
    return cnt >= last;
  endfunction

  // Counting decode for the running flag
  function automatic logic is_counting(input swd_state_t st);
    return st == SWD_COUNT;
  endfunction

  // Expiry decode for the fault logic
  function automatic logic is_expired(input swd_state_t st);
    return st == SWD_EXPIRED;
  endfunction

  // Pin order: activity, float sense, manual reset
  assign pin_raw = {manual_reset_in_n, activity_float, activity_input};

  // Three-stage synchronisers with edge detection
  swd_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin_in(pin_raw),
    .reset_level(PIN_IDLE),
    .level_out(pin_level),
    .edge_out(pin_edge)
  );

  // Either sense of activity counts as an edge
  assign act_edge = pin_edge[PIN_ACT];
  assign act_floating = pin_level[PIN_FLOAT];
  assign manual_low = !pin_level[PIN_MR];

  // Reset is wanted while supply is low or manual reset held
  assign rst_cause = !supply_ok || manual_low;

  // Supervisor reset: hold while cause stands, then time the release
  always_comb begin
    rst_cnt_next = rst_cnt_reg;
    sup_rst_n_next = sup_rst_n_reg;
    if (rst_cause) begin
      rst_cnt_next = '0;
      sup_rst_n_next = 1'b0;
    end else if (!sup_rst_n_reg) begin
      if (count_done(32'(rst_cnt_reg), RST_HOLD_CYCLES - 32'd1)) begin
        sup_rst_n_next = 1'b1;
        rst_cnt_next = '0;
      end else begin
        rst_cnt_next = rst_cnt_reg + RST_W'(1);
      end
    end
  end

  // Supervisor reset registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
      sup_rst_n_reg <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      sup_rst_n_reg <= sup_rst_n_next;
    end
  end

  // Watchdog is held cleared while reset stands or the pin floats
  assign hold_rst = !sup_rst_n_reg;
  assign hold_float = act_floating;

  // Watchdog sequencing
  always_comb begin
    state_next = state_reg;
    wdt_cnt_next = wdt_cnt_reg;
    if (hold_rst) begin
      state_next = SWD_IDLE;
      wdt_cnt_next = '0;
    end else if (hold_float) begin
      state_next = SWD_IDLE;
      wdt_cnt_next = '0;
    end else begin
      case (state_reg)
        SWD_IDLE: begin
          wdt_cnt_next = '0;
          state_next = SWD_ARMED;
        end
        SWD_ARMED: begin
          wdt_cnt_next = '0;
          if (act_edge) begin
            state_next = SWD_COUNT;
          end
        end
        SWD_COUNT: begin
          if (act_edge) begin
            wdt_cnt_next = '0;
          end else if (count_done(32'(wdt_cnt_reg), TIMEOUT_CYCLES - 32'd1)) begin
            state_next = SWD_EXPIRED;
            wdt_cnt_next = '0;
          end else begin
            wdt_cnt_next = wdt_cnt_reg + WDT_W'(1);
          end
        end
        SWD_EXPIRED: begin
          wdt_cnt_next = '0;
          if (act_edge) begin
            state_next = SWD_COUNT;
          end
        end
        default: begin
          state_next = SWD_IDLE;
          wdt_cnt_next = '0;
        end
      endcase
    end
  end

  // Fault causes, each pulls the output low on its own
  assign fault_supply = !supply_ok;
  assign fault_expiry = is_expired(state_next);

  // Fault output follows its causes with no stretching
  always_comb begin
    fault_n_next = 1'b1;
    if (fault_supply) begin
      fault_n_next = 1'b0;
    end else if (fault_expiry) begin
      fault_n_next = 1'b0;
    end
  end

  // Running flag mirrors the counting state
  always_comb begin
    running_next = is_counting(state_next);
  end

  // Watchdog registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SWD_IDLE;
      wdt_cnt_reg <= '0;
      fault_n_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wdt_cnt_reg <= wdt_cnt_next;
      fault_n_reg <= fault_n_next;
      running_reg <= running_next;
    end
  end

  // Outputs straight from flip-flops
  assign watchdog_fault_n = fault_n_reg;
  assign supervisor_reset_n = sup_rst_n_reg;
  assign watchdog_running = running_reg;
  assign watchdog_state = state_reg;
endmodule

// >>> bench/swd_checker.sv
`timescale 1ns/1ps
module swd_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic activity_input,
  input wire logic activity_float,
  input wire logic manual_reset_in_n,
  input wire logic supply_ok,
  input wire logic watchdog_fault_n,
  input wire logic supervisor_reset_n,
  input wire logic watchdog_running,
  input wire swd_pkg::swd_state_t watchdog_state
);
  import swd_pkg::*;
  int cnt_reg;
  logic [4:0] act_hist_reg;
  logic act_seen;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Pin history, so a restart is seen in the cycle the design acts on it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) act_hist_reg <= '0;
    else act_hist_reg <= {act_hist_reg[3:0], activity_input};
  end
  assign act_seen = act_hist_reg[3] != act_hist_reg[4];
  // Cycles spent counting since the last restart
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cnt_reg <= 0;
    else cnt_reg <= (watchdog_state == SWD_COUNT && !act_seen) ? cnt_reg + 1 : 0;
  end
  a_supply_low_fault: assert property (!supply_ok |=> !watchdog_fault_n)
    else $error("fault high with supply low");
  a_supply_up_release: assert property ($rose(supply_ok) && watchdog_state != SWD_EXPIRED
    |=> watchdog_fault_n) else $error("fault late on recovery");
  a_reset_clears: assert property (!supervisor_reset_n |=> watchdog_state == SWD_IDLE
    && !watchdog_running) else $error("watchdog active in reset");
  a_float_idle: assert property (activity_float [*7] |-> watchdog_state == SWD_IDLE)
    else $error("watchdog active while floating");
  a_expired_fault: assert property (watchdog_state == SWD_EXPIRED |-> !watchdog_fault_n)
    else $error("expired without fault");
  a_no_early_expiry: assert property ($past(watchdog_state) == SWD_COUNT && watchdog_state
    == SWD_EXPIRED |-> cnt_reg == TIMEOUT_CYCLES) else $error("expiry off its count");
  a_expired_sticky: assert property (watchdog_state == SWD_EXPIRED && supply_ok && !activity_float
    && supervisor_reset_n && manual_reset_in_n |=> watchdog_state inside {SWD_EXPIRED, SWD_COUNT})
    else $error("expiry left without edge");
  a_restart_release: assert property ($past(watchdog_state) == SWD_EXPIRED && watchdog_state
    == SWD_COUNT |-> watchdog_fault_n) else $error("fault kept after edge");
endmodule
bind swd_watchdog swd_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) swd_checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .activity_input(activity_input),
  .activity_float(activity_float), .manual_reset_in_n(manual_reset_in_n),
  .supply_ok(supply_ok), .watchdog_fault_n(watchdog_fault_n),
  .supervisor_reset_n(supervisor_reset_n), .watchdog_running(watchdog_running),
  .watchdog_state(watchdog_state));

// >>> bench/swd_host_model.sv
`timescale 1ns/1ps
module swd_host_model (
  input wire logic core_clk,
  input wire logic toggle_req,
  input wire logic float_en,
  output logic activity_input
);
  logic level_reg = 1'b0;
  logic noise_reg = 1'b0;
  int hold_reg = 0;
  // Flip the level only once it has stood 50 ns
  always @(posedge core_clk) begin
    hold_reg <= hold_reg + 1;
    noise_reg <= ~noise_reg;
    if (toggle_req && hold_reg >= 7) begin
      level_reg <= ~level_reg;
      hold_reg <= 0;
    end
  end
  // Released pin shows a changing pattern
  assign activity_input = float_en ? noise_reg : level_reg;
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import swd_pkg::*;
  localparam int TO = 50;
  logic core_clk = 0, reset_n = 0, float_en = 0, mr_n = 1, supply_ok = 1, req = 0;
  logic act, fault_n, sup_n, running;
  swd_state_t st;
  int num_errors = 0, checks_done = 0, n;
  always #4 core_clk = ~core_clk;
  swd_host_model swd_host_model_inst (.core_clk(core_clk), .toggle_req(req),
    .float_en(float_en), .activity_input(act));
  swd_watchdog #(.TIMEOUT_CYCLES(TO), .RST_HOLD_CYCLES(20)) swd_watchdog_inst (
    .core_clk(core_clk), .reset_n(reset_n), .activity_input(act), .activity_float(float_en),
    .manual_reset_in_n(mr_n), .supply_ok(supply_ok), .watchdog_fault_n(fault_n),
    .supervisor_reset_n(sup_n), .watchdog_running(running), .watchdog_state(st));
  function int expire_lat(int t);
    return t + 5;
  endfunction
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task tick(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task toggle;
    @(posedge core_clk) req <= 1'b1;
    @(posedge core_clk) req <= 1'b0;
    #1;
  endtask
  task wait_state(swd_state_t s);
    n = 0;
    while (st !== s) begin
      tick(1);
      n++;
      if (n > 200) begin num_errors++; test_done; end
    end
  endtask
  task wait_sup;
    n = 0;
    while (sup_n !== 1'b1) begin
      tick(1);
      n++;
      if (n > 200) begin num_errors++; test_done; end
    end
    tick(2);
  endtask
  // Boot, restarts, expiry, float, brownout, manual reset
  initial begin
    n = $urandom(32'h7E07);
    tick(19);
    @(posedge core_clk) reset_n <= 1'b1;
    wait_sup;
    check("boot_hold", n inside {[18:28]}, 1);
    toggle;
    wait_state(SWD_COUNT);
    check("start_lat", n inside {[4:6]}, 1);
    repeat (6) begin
      tick(8 + $urandom % 35);
      toggle;
      check("restart_fault", fault_n, 1);
      check("restart_state", st, SWD_COUNT);
      check("restart_run", running, 1);
    end
    wait_state(SWD_EXPIRED);
    check("expiry_lat", n inside {[expire_lat(TO) - 1:expire_lat(TO) + 1]}, 1);
    check("expiry_fault", fault_n, 0);
    check("expiry_run", running, 0);
    tick(30);
    check("fault_held", fault_n, 0);
    toggle;
    wait_state(SWD_COUNT);
    check("fault_cleared", fault_n, 1);
    @(posedge core_clk) float_en <= 1'b1;
    tick(TO + 10);
    check("float_state", st, SWD_IDLE);
    check("float_fault", fault_n, 1);
    @(posedge core_clk) float_en <= 1'b0;
    tick(8);
    toggle;
    @(posedge core_clk) supply_ok <= 1'b0;
    tick(2);
    check("low_fault", fault_n, 0);
    tick(3);
    check("low_state", st, SWD_IDLE);
    @(posedge core_clk) supply_ok <= 1'b1;
    tick(2);
    check("up_fault", fault_n, 1);
    check("up_reset", sup_n, 0);
    wait_sup;
    check("up_hold", n inside {[16:22]}, 1);
    toggle;
    @(posedge core_clk) mr_n <= 1'b0;
    tick(6);
    check("manual_state", st, SWD_IDLE);
    @(posedge core_clk) mr_n <= 1'b1;
    wait_sup;
    test_done;
  end
endmodule
